// *** rtl/ims_consts.svh ***
// ims_consts.svh: register indices, field positions and reset values
// assumes: included by bare name from the mirror select block files
`ifndef IMS_CONSTS_SVH
`define IMS_CONSTS_SVH

// ==========================================================
// register indices (byte address = 4 * index)
`define IMS_IDX_CAPTURE 6'h10
`define IMS_IDX_CTRL 6'h12
`define IMS_IDX_DIV 6'h14
`define IMS_IDX_ADDR_LO 6'h16
`define IMS_IDX_ADDR_HI 6'h18
`define IMS_IDX_STATUS 6'h19

// ==========================================================
// field positions
`define IMS_CAP_EN_BIT 15
`define IMS_CAP_ID_MSB 3
`define IMS_FILT_MSB 15
`define IMS_FILT_LSB 14
`define IMS_DIV_EN_BIT 13
`define IMS_MASK_MSB 8
`define IMS_DIV_MSB 9

// ==========================================================
// filter codes and reset values
`define IMS_FILT_ALL 2'h0
`define IMS_FILT_DA 2'h1
`define IMS_FILT_SA 2'h2
`define IMS_MASK_RST 9'h000
`define IMS_DIV_RST 10'h000
`define IMS_ADDR_RST 48'h0000_0000_0000
`define IMS_RSVD_MASK 9'h0c0

`endif

// *** rtl/ims_pkg.sv ***
// ims_pkg.sv: types shared by the mirror select block
// assumes: nothing beyond a SystemVerilog compiler
package ims_pkg;
    typedef struct packed {
        logic [15:0] handle;
        logic [3:0] src_port;
        logic mirror;
        logic [3:0] cap_port;
    } ims_desc_s;
endpackage : ims_pkg

// *** rtl/ims_stream_if.sv ***
// ims_stream_if.sv: valid/ready carrier for decided frame descriptors
// assumes: one producer and one consumer on the same clock
`timescale 1ns/1ps
`default_nettype none
interface ims_stream_if;
    import ims_pkg::*;
    logic valid;
    logic ready;
    ims_desc_s data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : ims_stream_if
`default_nettype wire

// *** rtl/ims_buf2.sv ***
// ims_buf2.sv: two-entry buffer, head entry drives the outputs from flops
// assumes: synchronous reset, ce freezes all state
`timescale 1ns/1ps
`default_nettype none
module ims_buf2
    import ims_pkg::*;
(
    // clock and control
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // streams
    ims_stream_if.snk wr,
    ims_stream_if.src rd
);
    ims_desc_s s0_reg, s0_next, s1_reg, s1_next;
    logic [1:0] cnt_reg, cnt_next;
    logic vld_reg, vld_next, rdy_reg, rdy_next;
    logic push, pop;

    assign push = wr.valid & rdy_reg;
    assign pop = vld_reg & rd.ready;

    // ==========================================================
    // next state
    always_comb begin
        s0_next = s0_reg;
        s1_next = s1_reg;
        cnt_next = cnt_reg;
        if (push && pop) begin
            if (cnt_reg == 2'h2) begin
                s0_next = s1_reg;
                s1_next = wr.data;
            end else begin
                s0_next = wr.data;
            end
        end else if (pop) begin
            s0_next = s1_reg;
            cnt_next = cnt_reg - 2'h1;
        end else if (push) begin
            if (cnt_reg == 2'h0) begin
                s0_next = wr.data;
            end else begin
                s1_next = wr.data;
            end
            cnt_next = cnt_reg + 2'h1;
        end
        // registered flags: a stall downstream fills both entries, then ready drops
        vld_next = (cnt_next != 2'h0);
        rdy_next = (cnt_next != 2'h2);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s0_reg <= '0;
            s1_reg <= '0;
            cnt_reg <= 2'h0;
            vld_reg <= 1'b0;
            rdy_reg <= 1'b0;
        end else if (ce_i) begin
            s0_reg <= s0_next;
            s1_reg <= s1_next;
            cnt_reg <= cnt_next;
            vld_reg <= vld_next;
            rdy_reg <= rdy_next;
        end
    end

    assign wr.ready = rdy_reg;
    assign rd.valid = vld_reg;
    assign rd.data = s0_reg;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_buf_no_loss: assert property (ce_i && push |=> vld_reg)
        else $error("accepted word not presented");
    chk_buf_hold: assert property (vld_reg && !rd.ready |=> vld_reg && $stable(s0_reg))
        else $error("head changed while stalled");
endmodule : ims_buf2
`default_nettype wire

// *** rtl/ims_mirror_select.sv ***
// ims_mirror_select.sv: ingress mirror selection with classic wishbone registers
// assumes: frame pipeline and bus master on clk_i, synchronous active high reset
`timescale 1ns/1ps
`default_nettype none
`include "ims_consts.svh"

// Function
// - nine-bit port mask, bit8 management, reset zero
// - masked ports' received frames copied to capture
// - many mask bits allowed, nothing lost
// - divider mirrors one of div plus one
// - 48-bit address compared to DA or SA
// - filter code: all, DA match, SA match
// - divider enable bit13; off mirrors every passer
// - global enable bit15; 4-bit capture port id
module ims_mirror_select
    import ims_pkg::*;
(
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // received frame descriptors
    input wire logic rx_valid_i,
    output logic rx_ready_o,
    input wire logic [15:0] rx_handle_i,
    input wire logic [3:0] rx_port_i,
    input wire logic [47:0] rx_da_i,
    input wire logic [47:0] rx_sa_i,
    // mirror decisions
    output logic dec_valid_o,
    input wire logic dec_ready_i,
    output logic [15:0] dec_handle_o,
    output logic [3:0] dec_port_o,
    output logic dec_mirror_o,
    output logic [3:0] dec_capture_port_o
);
    // ==========================================================
    // register file state
    logic cap_en_reg, cap_en_next;
    logic [3:0] cap_id_reg, cap_id_next;
    logic [1:0] filt_reg, filt_next;
    logic div_en_reg, div_en_next;
    logic [8:0] mask_reg, mask_next;
    logic [9:0] div_reg, div_next;
    logic [47:0] addr_reg, addr_next;
    logic ack_reg, ack_next;
    logic [31:0] dat_reg, dat_next;
    logic [5:0] idx;
    logic [31:0] rd_word, wr_word;

    // ==========================================================
    // selection state
    logic [9:0] cnt_reg, cnt_next;
    logic accept, port_sel, filt_pass, cand, mirror_dec;
    ims_desc_s in_desc;

    ims_stream_if wr_if ();
    ims_stream_if rd_if ();

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_w, input logic [31:0] new_w,
                                                input logic [3:0] sel);
        logic [31:0] res;
        res = old_w;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[8*b +: 8] = new_w[8*b +: 8];
            end
        end
        return res;
    endfunction : merge_bytes

    assign idx = wb_adr_i[7:2];

    // ==========================================================
    // read image, reserved bits read zero
    always_comb begin
        case (idx)
            `IMS_IDX_CAPTURE: rd_word = {16'h0000, cap_en_reg, 11'h000, cap_id_reg};
            `IMS_IDX_CTRL: rd_word = {16'h0000, filt_reg, div_en_reg, 4'h0, mask_reg};
            `IMS_IDX_DIV: rd_word = {22'h00_0000, div_reg};
            `IMS_IDX_ADDR_LO: rd_word = addr_reg[31:0];
            `IMS_IDX_ADDR_HI: rd_word = {16'h0000, addr_reg[47:32]};
            `IMS_IDX_STATUS: rd_word = {22'h00_0000, cnt_reg};
            default: rd_word = 32'h0000_0000;
        endcase
    end

    assign wr_word = merge_bytes(rd_word, wb_dat_i, wb_sel_i);

    // ==========================================================
    // bus slave: ack one cycle after request, dropped the cycle after
    always_comb begin
        cap_en_next = cap_en_reg;
        cap_id_next = cap_id_reg;
        filt_next = filt_reg;
        div_en_next = div_en_reg;
        mask_next = mask_reg;
        div_next = div_reg;
        addr_next = addr_reg;
        ack_next = wb_cyc_i & wb_stb_i & ~ack_reg;
        dat_next = 32'h0000_0000;
        if (ack_next && !wb_we_i) begin
            dat_next = rd_word;
        end
        if (ack_next && wb_we_i) begin
            case (idx)
                `IMS_IDX_CAPTURE: begin
                    cap_en_next = wr_word[`IMS_CAP_EN_BIT];
                    cap_id_next = wr_word[`IMS_CAP_ID_MSB:0];
                end
                `IMS_IDX_CTRL: begin
                    filt_next = wr_word[`IMS_FILT_MSB:`IMS_FILT_LSB];
                    div_en_next = wr_word[`IMS_DIV_EN_BIT];
                    mask_next = wr_word[`IMS_MASK_MSB:0] & ~`IMS_RSVD_MASK;
                end
                `IMS_IDX_DIV: div_next = wr_word[`IMS_DIV_MSB:0];
                `IMS_IDX_ADDR_LO: addr_next[31:0] = wr_word;
                `IMS_IDX_ADDR_HI: addr_next[47:32] = wr_word[15:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cap_en_reg <= 1'b0;
            cap_id_reg <= 4'h0;
            filt_reg <= `IMS_FILT_ALL;
            div_en_reg <= 1'b0;
            mask_reg <= `IMS_MASK_RST;
            div_reg <= `IMS_DIV_RST;
            addr_reg <= `IMS_ADDR_RST;
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else if (ce_i) begin
            cap_en_reg <= cap_en_next;
            cap_id_reg <= cap_id_next;
            filt_reg <= filt_next;
            div_en_reg <= div_en_next;
            mask_reg <= mask_next;
            div_reg <= div_next;
            addr_reg <= addr_next;
            ack_reg <= ack_next;
            dat_reg <= dat_next;
        end
    end

    // ==========================================================
    // selection: port mask, address filter, divider
    assign accept = ce_i & rx_valid_i & wr_if.ready;
    // reserved mask bits are never stored, so ports 6 and 7 never select
    assign port_sel = (rx_port_i <= 4'h8) && mask_reg[rx_port_i];

    always_comb begin
        unique case (filt_reg)
            `IMS_FILT_ALL: filt_pass = 1'b1;
            `IMS_FILT_DA: filt_pass = (rx_da_i == addr_reg);
            `IMS_FILT_SA: filt_pass = (rx_sa_i == addr_reg);
            default: filt_pass = 1'b0; // reserved code mirrors nothing
        endcase
    end

    // counting is gated by the global enable and the port mask so a disabled port does not advance the phase
    assign cand = cap_en_reg & port_sel & filt_pass;
    // >= guards against the divider being lowered below a running count
    assign mirror_dec = cand & (!div_en_reg || cnt_reg >= div_reg);

    always_comb begin
        cnt_next = cnt_reg;
        if (accept && cand && div_en_reg) begin
            if (cnt_reg >= div_reg) begin
                cnt_next = 10'h000;
            end else begin
                cnt_next = cnt_reg + 10'h001;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= 10'h000;
        end else if (ce_i) begin
            cnt_reg <= cnt_next;
        end
    end

    // ==========================================================
    // decision buffer
    always_comb begin
        in_desc.handle = rx_handle_i;
        in_desc.src_port = rx_port_i;
        in_desc.mirror = mirror_dec;
        in_desc.cap_port = cap_id_reg;
    end

    assign wr_if.valid = rx_valid_i;
    assign wr_if.data = in_desc;
    assign rd_if.ready = dec_ready_i;

    ims_buf2 u_buf (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .wr(wr_if.snk),
        .rd(rd_if.src)
    );

    assign rx_ready_o = wr_if.ready;
    assign dec_valid_o = rd_if.valid;
    assign dec_handle_o = rd_if.data.handle;
    assign dec_port_o = rd_if.data.src_port;
    assign dec_mirror_o = rd_if.data.mirror;
    assign dec_capture_port_o = rd_if.data.cap_port;
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_mask_reset_zero: assert property ($fell(rst_i) |-> mask_reg == 9'h000 && cnt_reg == 10'h000)
        else $error("mask not zero after reset");
    chk_unmasked_port: assert property (accept && !port_sel |-> !mirror_dec)
        else $error("unselected port mirrored");
    chk_global_off: assert property (accept && !cap_en_reg |-> !mirror_dec)
        else $error("mirrored while globally disabled");
    chk_filter_da_miss: assert property (accept && filt_reg == 2'h1 && rx_da_i != addr_reg |-> !mirror_dec)
        else $error("destination filter passed a mismatch");
    chk_filter_sa_miss: assert property (accept && filt_reg == 2'h2 && rx_sa_i != addr_reg |-> !mirror_dec)
        else $error("source filter passed a mismatch");
    chk_div_off_all: assert property (accept && cand && !div_en_reg |-> mirror_dec)
        else $error("passing frame not mirrored without divider");
    chk_div_count_up: assert property (accept && cand && div_en_reg && !mirror_dec
                                       |=> cnt_reg == $past(cnt_reg) + 10'h001)
        else $error("divider count did not advance");
    chk_div_restart: assert property (accept && cand && div_en_reg && mirror_dec |=> cnt_reg == 10'h000)
        else $error("divider did not restart");
    chk_wb_ack_once: assert property (ce_i && wb_cyc_i && wb_stb_i && !ack_reg |=> ack_reg ##1 !ack_reg)
        else $error("ack not a single cycle answer");
    chk_cap_port: assert property (accept && !rd_if.valid |=> rd_if.data.cap_port == $past(cap_id_reg))
        else $error("capture port id not taken at acceptance");
endmodule : ims_mirror_select
`default_nettype wire

// *** tb/ims_tb.sv ***
// ims_tb.sv: self-checking bench for the ingress mirror select block
// assumes: design files and ims_pkg compiled first, ce_i held high
`timescale 1ns/1ps
`default_nettype none
`include "ims_consts.svh"
module testbench;
    import ims_pkg::*;
// ==========================================================
// signals and model state
logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, rx_valid_i, dec_ready_i, stall;
logic [7:0] wb_adr_i;
logic [31:0] wb_dat_i, wb_dat_o;
logic wb_ack_o, rx_ready_o, dec_valid_o, dec_mirror_o;
logic [15:0] rx_handle_i, dec_handle_o, hnd;
logic [3:0] rx_port_i, dec_port_o, dec_capture_port_o, cap;
logic [47:0] rx_da_i, rx_sa_i, mac, r48;
logic en, den;
logic [1:0] filt;
logic [8:0] mask;
logic [9:0] div, cnt;
int seed = 69, num_errors = 0, checked = 0, cyc = 0;
logic [31:0] rq[$];
ims_desc_s fq[$];
ims_mirror_select u_ims_mirror_select (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o), .rx_handle_i(rx_handle_i),
    .rx_port_i(rx_port_i), .rx_da_i(rx_da_i), .rx_sa_i(rx_sa_i), .dec_valid_o(dec_valid_o),
    .dec_ready_i(dec_ready_i), .dec_handle_o(dec_handle_o), .dec_port_o(dec_port_o),
    .dec_mirror_o(dec_mirror_o), .dec_capture_port_o(dec_capture_port_o));
// ==========================================================
// compare, report and bus tasks
task chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
        num_errors++;
        $display("wrong value at %0t: register got %h exp %h", $time, got, exp);
    end
endtask : chk_reg
task chk_dec(input ims_desc_s got, input ims_desc_s exp);
    checked++;
    if (got !== exp) begin
        num_errors++;
        $display("wrong value at %0t: decision got %h exp %h", $time, got, exp);
    end
endtask : chk_dec
task test_done;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
        $display("Simulation passed");
    else
        $display("Simulation failed");
    $finish;
endtask : test_done
// request held until ack; released only at the ack edge
task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
endtask : wb
task rd(input logic [7:0] a, input logic [31:0] exp);
    rq.push_back(exp);
    wb(1'b0, a, 32'h0000_0000);
endtask : rd
task cfg(input logic e, input logic [3:0] c, input logic [1:0] f, input logic de,
         input logic [8:0] m, input logic [9:0] dv, input logic [47:0] mc);
    en = e; cap = c; filt = f; den = de; mask = m & 9'h13f; div = dv; mac = mc;
    wb(1'b1, 8'h40, {16'h0000, e, 11'h000, c});
    wb(1'b1, 8'h48, {16'h0000, f, de, 4'h0, m});
    wb(1'b1, 8'h50, {22'h00_0000, dv});
    wb(1'b1, 8'h58, mc[31:0]);
    wb(1'b1, 8'h60, {16'h0000, mc[47:32]});
endtask : cfg
// valid left high between frames so back to back transfers stay legal
task send(input logic [3:0] p, input logic [47:0] da, input logic [47:0] sa);
    logic cand, m;
    rx_valid_i <= 1'b1;
    rx_handle_i <= hnd;
    rx_port_i <= p;
    rx_da_i <= da;
    rx_sa_i <= sa;
    do @(posedge clk_i); while (rx_ready_o !== 1'b1);
    cand = en && p <= 4'h8 && mask[p] && (filt == 2'h0 || (filt == 2'h1 && da == mac) ||
        (filt == 2'h2 && sa == mac));
    m = cand && (!den || cnt >= div);
    if (cand && den)
        cnt = (cnt >= div) ? 10'h000 : cnt + 10'h001;
    fq.push_back('{handle: hnd, src_port: p, mirror: m, cap_port: cap});
    hnd++;
endtask : send
task idle;
    rx_valid_i <= 1'b0;
    @(posedge clk_i);
endtask : idle
// ==========================================================
// clock, stall source, timeout and result watcher
initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
end
always @(posedge clk_i) begin
    dec_ready_i <= !stall && ($unsigned($random(seed)) % 4 != 0);
    cyc++;
    if (cyc > 20000) begin
        num_errors++;
        test_done;
    end
end
always @(posedge clk_i) begin
    if (!rst_i && wb_ack_o === 1'b1 && wb_we_i === 1'b0 && rq.size() > 0)
        chk_reg(wb_dat_o, rq.pop_front());
    if (!rst_i && dec_valid_o === 1'b1 && dec_ready_i === 1'b1 && fq.size() > 0)
        chk_dec({dec_handle_o, dec_port_o, dec_mirror_o, dec_capture_port_o}, fq.pop_front());
end
// ==========================================================
// main sequence
initial begin
    rst_i = 1'b1; wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0; wb_adr_i = 8'h00;
    wb_dat_i = 32'h0000_0000; rx_valid_i = 1'b0; rx_handle_i = 16'h0000; rx_port_i = 4'h0;
    rx_da_i = 48'h0; rx_sa_i = 48'h0; stall = 1'b0; hnd = 16'h0000;
    cnt = 10'h000;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk_reg({31'h0, rx_ready_o}, 32'h0000_0001);
    rd(8'h48, 32'h0000_0000);
    rd(8'h50, 32'h0000_0000);
    rd(8'h58, 32'h0000_0000);
    $display("test reset values done");
    // divider: non-candidate frames on port 1 must not advance the count
    for (int i = 1; i >= 0; i--) begin
        cfg(1'b1, 4'h5, 2'h0, 1'b1, 9'h001, i ? 10'h000 : 10'h002, 48'h0);
        for (int k = 0; k < 7; k++) begin
            send(4'h0, 48'h1, 48'h2);
            send(4'h1, 48'h1, 48'h2);
        end
        idle;
        rd(8'h64, {22'h0, cnt});
    end
    $display("test divider done");
    // every filter code, then global enable off; random ports and addresses
    for (int i = 0; i < 5; i++) begin
        r48 = {16'($random(seed)), 32'($random(seed))};
        cfg(i != 4, 4'($random(seed)), 2'(i), 1'b0, 9'($random(seed)), 10'h000, r48);
        for (int k = 0; k < 24; k++) begin
            r48 = {16'($random(seed)), 32'($random(seed))};
            send(4'($unsigned($random(seed)) % 10), $random(seed) % 2 ? mac : r48,
                $random(seed) % 2 ? mac : ~r48);
        end
        idle;
    end
    $display("test filters done");
    // reserved bits read zero; unmapped reads zero and ignores writes
    wb(1'b1, 8'h48, 32'hffff_ffff);
    rd(8'h48, 32'h0000_e13f);
    wb(1'b1, 8'h50, 32'h0000_03ff);
    rd(8'h50, 32'h0000_03ff);
    wb(1'b1, 8'h60, 32'hffff_ffff);
    rd(8'h60, 32'h0000_ffff);
    wb(1'b1, 8'hfc, 32'hffff_ffff);
    rd(8'hfc, 32'h0000_0000);
    $display("test reserved bits done");
    // consumer stalls: two entries fill, then input is refused
    cfg(1'b1, 4'h3, 2'h0, 1'b0, 9'h1ff, 10'h000, 48'h0);
    rd(8'h40, 32'h0000_8003);
    stall = 1'b1;
    repeat (4) @(posedge clk_i);
    send(4'h8, 48'h0, 48'h0);
    send(4'h2, 48'h0, 48'h0);
    idle;
    @(posedge clk_i);
    chk_reg({31'h0, rx_ready_o}, 32'h0000_0000);
    stall = 1'b0;
    for (int k = 0; k < 200 && fq.size() > 0; k++)
        @(posedge clk_i);
    chk_reg(fq.size(), 32'h0000_0000);
    $display("test stall done");
    test_done;
end
endmodule : testbench
`default_nettype wire
